// ### dv/sdp_checker_assertions.sv
// Purpose: output and bus checks on the serial dac port top
// Assumes: every watched signal belongs to the clk domain
// Notes:   pin synchronisers add two clk edges of delay
`timescale 1ns/10ps
module sdp_checker_assertions #(
    parameter int unsigned RES = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bus side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // pins and converter side
    input wire logic frame_sel_n,
    input wire logic load_output_n,
    input wire logic clear_output_n,
    input wire logic external_reset_n,
    input wire logic [RES-1:0] dac_level,
    input wire logic output_clamped
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic [3:0] quiet_ff;
    logic [3:0] nxt_quiet;

    // --------------------------------------------------------------
    // cycles since load or clear was low
    // --------------------------------------------------------------
    // saturating, so a long quiet spell never wraps back to zero
    always_comb begin
        nxt_quiet = quiet_ff;
        if (!load_output_n || !clear_output_n) begin
            nxt_quiet = 4'h0;
        end else if (quiet_ff != 4'hF) begin
            nxt_quiet = quiet_ff + 4'h1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            quiet_ff <= 4'hF;
        end else begin
            quiet_ff <= nxt_quiet;
        end
    end

    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    ext_clamp_a: assert property (
        !external_reset_n [*5] |-> output_clamped)
        else $error("clamp missing under external reset");
    ext_hold_a: assert property (
        !external_reset_n [*5] |=> $stable(dac_level))
        else $error("level moved under external reset");
    reset_clamp_a: assert property (
        $rose(rstn) |-> output_clamped && dac_level == '0)
        else $error("wrong outputs after reset");
    clear_level_a: assert property (
        (!clear_output_n && external_reset_n) [*5] |->
        dac_level == '0 || dac_level == {1'b1, {(RES-1){1'b0}}})
        else $error("clear level wrong");
    deselect_hold_a: assert property (
        (frame_sel_n && clear_output_n && $stable(load_output_n)) [*8]
        |=> $stable(dac_level))
        else $error("level moved while deselected");
    level_read_a: assert property (
        hsel && hready && htrans[1] && !hwrite &&
        haddr == sdp_pkg::LEVEL_OFS |=>
        hrdata == {{(32-RES){1'b0}}, $past(dac_level)})
        else $error("level read wrong");
    level_cause_a: assert property (
        $changed(dac_level) |-> quiet_ff < 4'h6)
        else $error("level moved with no load or clear");
    clamp_release_a: assert property (
        $fell(output_clamped) |-> quiet_ff < 4'h6 && external_reset_n)
        else $error("clamp released with no load");
endmodule

// ### dv/sdp_host.sv
// Purpose: host model driving framed serial words into the port
// Assumes: shift clock stands low between frames
// Notes:   records the chain output just before each falling shift edge
`timescale 1ns/10ps
module sdp_host (
    // link pins towards the port
    output logic shift_clk,
    output logic frame_sel_n,
    output logic serial_word_in,
    // chain output and what it showed in the last frame
    input wire logic chain_data_out,
    output logic [15:0] chain_cap
);
    // ------------------------------------------------------------
    // idle state
    // ------------------------------------------------------------
    initial begin
        shift_clk = 1'b0;
        frame_sel_n = 1'b1;
        serial_word_in = 1'b0;
        chain_cap = 16'h0000;
    end

    // msb-first frame of bits
    // data flips after the frame so a stale bit is never reused
    task automatic send(input logic [15:0] w, input int n);
        frame_sel_n = 1'b0;
        #50;
        for (int i = 0; i < n; i++) begin
            serial_word_in = w[15-i];
            #12;
            shift_clk = 1'b1;
            #24;
            chain_cap = {chain_cap[14:0], chain_data_out};
            shift_clk = 1'b0;
            #12;
        end
        serial_word_in = ~serial_word_in;
        #50;
        frame_sel_n = 1'b1;
        #50;
    endtask

    // clock and data wiggle while deselected
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            serial_word_in = i[0];
            #12;
            shift_clk = 1'b1;
            #24;
            shift_clk = 1'b0;
            #12;
        end
    endtask
endmodule

// ### dv/tb_serial_dac_input_port.sv
// Purpose: self-checking bench for the serial dac port top
// Assumes: one bus slave, load pin mostly held low (auto load)
// Notes:   link waits rest on the sync latency from the hand-over
`timescale 1ns/10ps
module tb_serial_dac_input_port;
    logic clk = 1'b0;
    logic rstn;
    logic hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic shift_clk, frame_sel_n, serial_word_in, chain_data_out;
    logic load_output_n, clear_output_n, external_reset_n;
    logic output_clamped;
    logic [15:0] dac_level, chain_cap;
    int failures = 0;
    int checked = 0;

    always #5 clk = ~clk;
    assign hready = hreadyout;

    sdp_top #(.RES(16)) u_dut (.clk(clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .shift_clk(shift_clk),
        .frame_sel_n(frame_sel_n), .serial_word_in(serial_word_in),
        .chain_data_out(chain_data_out), .load_output_n(load_output_n),
        .clear_output_n(clear_output_n),
        .external_reset_n(external_reset_n), .dac_level(dac_level),
        .output_clamped(output_clamped));
    sdp_host u_host (.shift_clk(shift_clk), .frame_sel_n(frame_sel_n),
        .serial_word_in(serial_word_in), .chain_data_out(chain_data_out),
        .chain_cap(chain_cap));

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, e, s);
        end
    endtask
    // single word transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        check("hresp", hresp, 1'b0);
    endtask
    task automatic word(input logic [15:0] w);
        u_host.send(w, 16);
        repeat (10) @(posedge clk);
    endtask
    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_auto();
        ahb(1'b0, 32'h0000_0010, 32'h0);
        check("unmapped", q, 32'h0000_0000);
        ahb(1'b1, sdp_pkg::CTRL_OFS, 32'h0000_0000);
        load_output_n <= 1'b0;
        repeat (8) @(posedge clk);
        check("no word", output_clamped, 1'b1);
        word(16'hA5C3);
        ahb(1'b0, sdp_pkg::RXWORD_OFS, 32'h0);
        check("rxword", q, 32'h0000_A5C3);
        ahb(1'b0, sdp_pkg::LEVEL_OFS, 32'h0);
        check("level", q, 32'h0000_A5C3);
        check("clamp", output_clamped, 1'b0);
        ahb(1'b0, sdp_pkg::STATUS_OFS, 32'h0);
        check("status", q, 32'h0001_0000);
        // a short frame is dropped and the next one starts afresh
        u_host.send(16'hFFFF, 5);
        word(16'h00F0);
        check("restart", dac_level, 16'h00F0);
        // clock and data activity while deselected changes nothing
        u_host.noise(20);
        repeat (10) @(posedge clk);
        check("deselect", dac_level, 16'h00F0);
        ahb(1'b0, sdp_pkg::STATUS_OFS, 32'h0);
        check("no count", q, 32'h0002_0000);
        $display("done auto load");
    endtask
    task automatic t_coding();
        logic [2:0] ct [4] = '{3'h4, 3'h5, 3'h5, 3'h1};
        logic [15:0] wd [4] = '{16'h8000, 16'h0000, 16'h7FFF, 16'h1234};
        logic [15:0] ex [4] = '{16'h8000, 16'h8000, 16'hFFFF, 16'h1234};
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, sdp_pkg::CTRL_OFS, {29'h0, ct[i]});
            word(wd[i]);
            check("coding", dac_level, ex[i]);
        end
        $display("done coding");
    endtask
    task automatic t_load();
        ahb(1'b1, sdp_pkg::CTRL_OFS, 32'h0000_0000);
        load_output_n <= 1'b1;
        word(16'h4321);
        check("held", dac_level, 16'h1234);
        ahb(1'b0, sdp_pkg::STATUS_OFS, 32'h0);
        check("pending", q[1], 1'b1);
        load_output_n <= 1'b0;
        repeat (8) @(posedge clk);
        check("loaded", dac_level, 16'h4321);
        $display("done load edge");
    endtask
    task automatic t_clear();
        ahb(1'b1, sdp_pkg::CTRL_OFS, 32'h0000_0005);
        clear_output_n <= 1'b0;
        repeat (8) @(posedge clk);
        check("clear twos", dac_level, 16'h8000);
        ahb(1'b1, sdp_pkg::CTRL_OFS, 32'h0000_0000);
        repeat (8) @(posedge clk);
        check("clear uni", dac_level, 16'h0000);
        clear_output_n <= 1'b1;
        external_reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        check("ext clamp", output_clamped, 1'b1);
        external_reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        check("clamp kept", output_clamped, 1'b1);
        word(16'h0F0F);
        check("unclamped", output_clamped, 1'b0);
        $display("done clear and reset");
    endtask
    task automatic t_chain();
        // chaining set only for this cascade case
        ahb(1'b1, sdp_pkg::CTRL_OFS, 32'h0000_0002);
        word(16'hC35A);
        word(16'h9E61);
        check("chain", chain_cap, 16'hC35A);
        ahb(1'b1, sdp_pkg::CTRL_OFS, 32'h0000_0000);
        word(16'h5555);
        word(16'hAAAA);
        check("chain off", chain_cap, 16'h0000);
        $display("done chain");
    endtask

    // --------------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        load_output_n = 1'b1;
        clear_output_n = 1'b1;
        external_reset_n = 1'b1;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_auto();
        t_coding();
        t_load();
        t_clear();
        t_chain();
        results();
    end
    // run needs well under 60 us
    initial begin
        #300000;
        failures++;
        $display("watchdog expired");
        results();
    end
endmodule

bind sdp_top sdp_checker_assertions #(.RES(RES)) u_chk (.clk(clk),
    .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .frame_sel_n(frame_sel_n), .load_output_n(load_output_n),
    .clear_output_n(clear_output_n),
    .external_reset_n(external_reset_n), .dac_level(dac_level),
    .output_clamped(output_clamped));

// ### src/sdp_link.sv
// Purpose: shift-clock side of the serial port: shifter, chain output
// Assumes: shift clock may stop between frames
// Notes:   word and toggle are read by the system side after a sync
`timescale 1ns/10ps
module sdp_link (
    // link clock and system reset
    input wire logic shift_clk,
    input wire logic rstn,
    // serial pins
    input wire logic frame_sel_n,
    input wire logic serial_word_in,
    output logic chain_data_out,
    // chain enable from the system domain (level)
    input wire logic chain_enable,
    // completed word towards the system domain
    output logic [sdp_pkg::WORD_W-1:0] word_out,
    output logic word_tgl
);

    logic frame_rst_n;
    logic chain_en_s;
    logic [sdp_pkg::CNT_W-1:0] cnt_ff;
    logic [sdp_pkg::CNT_W-1:0] nxt_cnt;
    logic [sdp_pkg::WORD_W-1:0] sr_ff;
    logic [sdp_pkg::WORD_W-1:0] nxt_sr;
    logic [sdp_pkg::WORD_W-1:0] word_ff;
    logic [sdp_pkg::WORD_W-1:0] nxt_word;
    logic tgl_ff;
    logic nxt_tgl;
    logic chain_ff;
    logic nxt_chain;

    // frame start clears
    // deselect holds the bit counter cleared, so the falling frame edge
    // always starts a fresh word even with the clock stopped
    assign frame_rst_n = rstn & ~frame_sel_n;

    // chain enable is static in use, but still crosses cleanly
    sdp_sync #(.W(1), .RST_VAL(1'b0)) u_chain_sync (
        .clk(shift_clk),
        .rstn(rstn),
        .din(chain_enable),
        .sync_out(chain_en_s)
    );

    // shifter next state, msb first
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_sr = sr_ff;
        nxt_word = word_ff;
        nxt_tgl = tgl_ff;
        if (!frame_sel_n) begin
            nxt_sr = {sr_ff[sdp_pkg::WORD_W-2:0], serial_word_in};
            nxt_cnt = sdp_pkg::CNT_W'(cnt_ff + 1'b1);
            if (cnt_ff == sdp_pkg::LAST_BIT) begin
                nxt_word = nxt_sr;
                nxt_tgl = ~tgl_ff;
            end
        end
    end

    // bit counter, cleared while deselected
    always_ff @(negedge shift_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // shift register and completed word on falling edges
    always_ff @(negedge shift_clk or negedge rstn) begin
        if (!rstn) begin
            sr_ff <= '0;
            word_ff <= '0;
            tgl_ff <= 1'b0;
        end else begin
            sr_ff <= nxt_sr;
            word_ff <= nxt_word;
            tgl_ff <= nxt_tgl;
        end
    end

    // chain out rising
    // low when chaining is off so an open output reads quiet
    always_comb begin
        nxt_chain = chain_en_s ? sr_ff[sdp_pkg::WORD_W-1] : 1'b0;
    end

    always_ff @(posedge shift_clk or negedge rstn) begin
        if (!rstn) begin
            chain_ff <= 1'b0;
        end else begin
            chain_ff <= nxt_chain;
        end
    end

    assign chain_data_out = chain_ff;
    assign word_out = word_ff;
    assign word_tgl = tgl_ff;

endmodule

// ### src/sdp_pkg.sv
// Purpose: shared constants and types for the serial DAC input port
// Assumes: 32-bit AHB-Lite register bus, 16-bit serial words
// Notes:   byte offsets are word aligned
package sdp_pkg;

    // ----------------------------------------------------------------
    // word format
    // ----------------------------------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned CNT_W = 4;
    localparam logic [3:0] LAST_BIT = 4'hF;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] RXWORD_OFS = 32'h0000_0004;
    localparam logic [31:0] LEVEL_OFS = 32'h0000_0008;
    localparam logic [31:0] STATUS_OFS = 32'h0000_000C;

    // control register fields
    localparam int unsigned CTRL_CODING_BIT = 0;
    localparam int unsigned CTRL_CHAIN_BIT = 1;
    localparam int unsigned CTRL_BIPOLAR_BIT = 2;
    localparam int unsigned CTRL_W = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // status register fields
    localparam int unsigned STAT_CLAMP_BIT = 0;
    localparam int unsigned STAT_PEND_BIT = 1;
    localparam int unsigned STAT_CNT_LSB = 16;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic bipolar;
        logic chain_en;
        logic coding;
    } sdp_ctrl_s;

    typedef struct packed {
        logic pend;
        logic clamp;
    } sdp_stat_s;

endpackage

// ### src/sdp_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: input is a level that stays put for several clocks
// Notes:   first stage feeds the second stage only
`timescale 1ns/10ps
module sdp_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // level in and synchronised level out
    input wire logic [W-1:0] din,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    // next values of both stages
    always_comb begin
        nxt_meta = din;
        nxt_sync = meta_ff;
    end

    // stage registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;

endmodule

// ### src/sdp_top.sv
// Purpose: serial DAC input port with AHB-Lite control registers
// Assumes: clk 100 MHz; shift clock from the host is its own domain
// Notes:   dac_level is the code as an unsigned step count from the
//          negative reference; output_clamped forces the output to 0 V
//          and only a freshly received word lifts it
// Functional notes
// - A falling frame select restarts the serial input logic.
// - Each falling shift-clock edge shifts one data bit in.
// - With chaining on, the shifter msb leaves on each rising edge.
// - Unipolar range always uses natural binary coding.
// - Bipolar range is offset binary at 0 and twos complement at 1.
// - Resolution is 16 bits, or 14 bits for the reduced grade.
// - While deselected, input activity leaves the loaded code alone.
// - In offset binary the code with only the msb set is midscale.
// - Load falling edge applies the word; held low it auto-loads.
// - Clear forces 0 V, or the negative reference in offset binary.
// - External reset clamps to 0 V until a word loads with it high.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module sdp_top #(
    parameter int unsigned RES = 16
) (
    // system clock and reset
    input wire logic clk,
    input wire logic rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // serial link
    input wire logic shift_clk,
    input wire logic frame_sel_n,
    input wire logic serial_word_in,
    output logic chain_data_out,
    // control pins
    input wire logic load_output_n,
    input wire logic clear_output_n,
    input wire logic external_reset_n,
    // converter side
    output logic [RES-1:0] dac_level,
    output logic output_clamped
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    // register file and status
    sdp_pkg::sdp_ctrl_s ctrl_ff;
    sdp_pkg::sdp_ctrl_s nxt_ctrl;
    sdp_pkg::sdp_stat_s stat_ff;
    sdp_pkg::sdp_stat_s nxt_stat;

    // bus slave pipeline
    logic wr_pend_ff;
    logic nxt_wr_pend;
    logic [31:0] wr_addr_ff;
    logic [31:0] nxt_wr_addr;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic ready_ff;
    logic resp_ff;
    logic addr_ok;

    // crossing and pin sync
    logic [sdp_pkg::WORD_W-1:0] link_word;
    logic link_tgl;
    logic tgl_s;
    logic [2:0] pins_s;
    logic load_s;
    logic clear_s;
    logic ext_rst_s;

    // edge history, word and level
    logic tgl_prev_ff;
    logic load_prev_ff;
    logic [sdp_pkg::WORD_W-1:0] rx_word_ff;
    logic [sdp_pkg::WORD_W-1:0] nxt_rx_word;
    logic [15:0] word_cnt_ff;
    logic [15:0] nxt_word_cnt;
    logic [RES-1:0] level_ff;
    logic [RES-1:0] nxt_level;

    // decoded events
    logic word_evt;
    logic load_fall;
    logic apply_now;
    logic twos;
    logic [sdp_pkg::WORD_W-1:0] apply_word;
    logic [RES-1:0] clear_level;

    // ----------------------------------------------------------------
    // code mapping
    // ----------------------------------------------------------------
    // top bits used
    // msb marks midscale
    // a twos complement code becomes offset binary by flipping the msb,
    // so one unsigned level feeds the converter in every mode
    function automatic logic [RES-1:0] map_code(
        input logic [sdp_pkg::WORD_W-1:0] w,
        input logic flip
    );
        logic [RES-1:0] c;
        c = w[sdp_pkg::WORD_W-1 -: RES];
        c[RES-1] = c[RES-1] ^ flip;
        return c;
    endfunction

    // ----------------------------------------------------------------
    // link domain
    // ----------------------------------------------------------------
    // the link runs on the host's shift clock; only the word
    // toggle, the held word and the chain bit cross, and the word
    // is settled long before its toggle is seen here
    sdp_link u_link (
        .shift_clk(shift_clk),
        .rstn(rstn),
        .frame_sel_n(frame_sel_n),
        .serial_word_in(serial_word_in),
        .chain_data_out(chain_data_out),
        .chain_enable(ctrl_ff.chain_en),
        .word_out(link_word),
        .word_tgl(link_tgl)
    );

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    // word toggle: the word itself is stable for a whole frame after it
    sdp_sync #(.W(1), .RST_VAL(1'b0)) u_tgl_sync (
        .clk(clk),
        .rstn(rstn),
        .din(link_tgl),
        .sync_out(tgl_s)
    );

    // every control pin passes two flops before logic reads it
    // active-low pins reset to their idle high level
    sdp_sync #(.W(3), .RST_VAL(3'h7)) u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .din({load_output_n, clear_output_n, external_reset_n}),
        .sync_out(pins_s)
    );

    // pin order: load, clear, external reset
    assign load_s = pins_s[2];
    assign clear_s = pins_s[1];
    assign ext_rst_s = pins_s[0];

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    // CTRL    rw: [0] coding, [1] chain, [2] bipolar range
    // RXWORD  ro: last complete word from the link
    // LEVEL   ro: level now driven to the converter
    // STATUS  ro: [0] clamped, [1] pending, [31:16] words
    // stray writes are dropped and unmapped reads give zero,
    // so the slave never needs an error response
    // hsize is not decoded: every access is a whole word
    // zero wait states: reads are looked up during the address phase
    assign addr_ok = hsel & hready & htrans[1];

    always_comb begin
        nxt_wr_pend = addr_ok & hwrite;
        nxt_wr_addr = addr_ok ? haddr : wr_addr_ff;
        nxt_rdata = rdata_ff;
        nxt_ctrl = ctrl_ff;
        if (addr_ok && !hwrite) begin
            nxt_rdata = '0;
            case (haddr)
                sdp_pkg::CTRL_OFS: begin
                    nxt_rdata[sdp_pkg::CTRL_W-1:0] = ctrl_ff;
                end
                sdp_pkg::RXWORD_OFS: begin
                    nxt_rdata[sdp_pkg::WORD_W-1:0] = rx_word_ff;
                end
                sdp_pkg::LEVEL_OFS: begin
                    nxt_rdata[RES-1:0] = level_ff;
                end
                sdp_pkg::STATUS_OFS: begin
                    nxt_rdata[sdp_pkg::STAT_CLAMP_BIT] = stat_ff.clamp;
                    nxt_rdata[sdp_pkg::STAT_PEND_BIT] = stat_ff.pend;
                    nxt_rdata[sdp_pkg::STAT_CNT_LSB +: 16] = word_cnt_ff;
                end
                default: begin
                    nxt_rdata = '0; // unmapped reads as zero
                end
            endcase
        end
        // only CTRL is writable; the rest are read only
        // write data arrives in the data phase
        if (wr_pend_ff && wr_addr_ff == sdp_pkg::CTRL_OFS) begin
            nxt_ctrl = hwdata[sdp_pkg::CTRL_W-1:0];
        end
    end

    // bus registers; ready and response stay fixed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            rdata_ff <= '0;
            ctrl_ff <= sdp_pkg::CTRL_RST;
            ready_ff <= 1'b1;
            resp_ff <= 1'b0;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            ready_ff <= 1'b1;
            resp_ff <= 1'b0;
        end
    end

    // outputs straight from registers
    assign hreadyout = ready_ff;
    assign hresp = resp_ff;
    assign hrdata = rdata_ff;

    // ----------------------------------------------------------------
    // load, clear and clamp control
    // ----------------------------------------------------------------
    // unipolar straight binary
    assign twos = ctrl_ff.bipolar & ctrl_ff.coding;

    // clear level
    // 0 V is level zero unipolar, mid level in twos complement;
    // in offset binary level zero is the negative reference
    assign clear_level = {twos, {(RES-1){1'b0}}};

    // word arrival and load edge, both on clk
    assign word_evt = tgl_s ^ tgl_prev_ff;
    assign load_fall = load_prev_ff & ~load_s;

    // edge or auto load
    // a word landing with load held low applies at once; if a load
    // edge meets a new word in the same cycle the new word wins
    assign apply_now = (word_evt & ~load_s) | load_fall;
    assign apply_word = word_evt ? link_word : rx_word_ff;

    always_comb begin
        nxt_rx_word = rx_word_ff;
        nxt_word_cnt = word_cnt_ff;
        nxt_level = level_ff;
        nxt_stat = stat_ff;
        if (word_evt) begin
            nxt_rx_word = link_word;
            nxt_word_cnt = 16'(word_cnt_ff + 1'b1);
            nxt_stat.pend = 1'b1;
        end
        // priority: external reset, then clear, then load
        // external reset clamps
        if (!ext_rst_s) begin
            nxt_stat.clamp = 1'b1;
        end else if (!clear_s) begin
            nxt_level = clear_level;
        end else if (apply_now) begin
            nxt_level = map_code(apply_word, twos);
            // fresh word lifts clamp
            // a bare load edge replaying the old word is no reload
            if (word_evt || stat_ff.pend) begin
                nxt_stat.clamp = 1'b0;
            end
            nxt_stat.pend = 1'b0;
        end
    end

    // output starts clamped until the first valid load
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tgl_prev_ff <= 1'b0;
            load_prev_ff <= 1'b1;
            rx_word_ff <= '0;
            word_cnt_ff <= '0;
            level_ff <= '0;
            stat_ff <= '{pend: 1'b0, clamp: 1'b1};
        end else begin
            tgl_prev_ff <= tgl_s;
            load_prev_ff <= load_s;
            rx_word_ff <= nxt_rx_word;
            word_cnt_ff <= nxt_word_cnt;
            level_ff <= nxt_level;
            stat_ff <= nxt_stat;
        end
    end

    // converter outputs, both registers
    assign dac_level = level_ff;
    assign output_clamped = stat_ff.clamp;

endmodule
